// ===== hw/mbrs_frame_engine.sv
// slave frame engine: serial receive, check code, read/write decode, reply
`timescale 1ns/1ps
`default_nettype none
module mbrs_frame_engine #(
  parameter int unsigned CLK_HZ         = 10_000_000,
  parameter int unsigned BAUD           = 9600,
  parameter int unsigned REG_FIRST      = 0,
  parameter int unsigned REG_LAST       = 255,
  parameter int unsigned SILENCE_CYCLES =
    (CLK_HZ * mbrs_pkg::GAP_HALF_CHARS * mbrs_pkg::CHAR_BITS + 2 * BAUD - 1) / (2 * BAUD)
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // serial line
  input  wire logic                    rx_pin,
  output logic                         tx_pin,
  output logic                         tx_drive,
  // configuration
  input  wire logic [7:0]              dev_addr,
  // meter register map
  output mbrs_pkg::mbrs_reg_req_t      reg_req,
  input  wire mbrs_pkg::mbrs_reg_rsp_t reg_rsp,
  // status
  output logic                         frame_drop,
  output logic                         reply_done
);
  import mbrs_pkg::*;

  localparam int unsigned BIT_CYC  = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int          DW       = $clog2(BIT_CYC + 1);
  localparam int          QW       = $clog2(SILENCE_CYCLES + 1);

  // ****************************************************************
  // receive path
  // ****************************************************************
  logic          rx_m;
  logic          rx_s;
  logic          rx_busy;
  logic [DW-1:0] rx_div;
  logic [3:0]    rx_bit;
  logic [7:0]    rx_sh;
  logic          rx_stb;
  logic          rx_ferr;
  logic [QW-1:0] quiet;
  wire           rx_tick    = rx_busy && (rx_div == '0);
  wire           line_quiet = (quiet == QW'(SILENCE_CYCLES));

  // two-stage synchroniser on the pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= rx_pin;
      rx_s <= rx_m;
    end
  end

  // character receiver: sample mid-bit, lsb first, stop bit checked
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_div  <= '0;
      rx_bit  <= 4'h0;
      rx_sh   <= 8'h00;
      rx_stb  <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s) begin
          rx_busy <= 1'b1;
          rx_div  <= DW'(HALF_CYC);
          rx_bit  <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_div <= DW'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;                          // glitch, not a start bit
        end else if (rx_bit == RX_STOP_POS) begin
          rx_busy <= 1'b0;
          rx_stb  <= 1'b1;
          rx_ferr <= !rx_s;
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rx_s, rx_sh[7:1]};              // data bits only
        end
      end else begin
        rx_div <= rx_div - DW'(1);
      end
    end
  end

  // silence timer; any line activity restarts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= '0;
    end else if (rx_busy || !rx_s) begin
      quiet <= '0;
    end else if (!line_quiet) begin
      quiet <= quiet + QW'(1);
    end
  end

  // ****************************************************************
  // frame collection
  // ****************************************************************
  mbrs_state_t state;
  mbrs_kind_t  kind;
  logic        armed;
  logic        in_frame;
  logic        frame_bad;
  logic [8:0]  rx_len;
  logic [7:0]  fc;
  logic [15:0] start;
  logic [15:0] count;
  logic [7:0]  bcount;
  logic [7:0]  last_b;
  logic [7:0]  prev_b;
  logic [15:0] crc_d1;
  logic [15:0] crc_d2;
  logic [15:0] rx_crc;
  logic [7:0]  mem_rdata;
  logic [8:0]  mem_raddr;

  // a frame may only open after a full silence
  wire accept   = rx_stb && (state == ST_RX) && (in_frame || armed);
  wire first_b  = accept && !in_frame;
  wire addr_cfg = (dev_addr >= ADDR_MIN) && (dev_addr <= ADDR_MAX);
  wire addr_hit = addr_cfg && (rx_sh == dev_addr);
  wire frame_end = in_frame && line_quiet;

  // preset on the first byte, one byte per accept
  mbrs_crc16 u_rx_crc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clear   (first_b),
    .en      (accept),
    .data    (rx_sh),
    .crc     (rx_crc)
  );

  mbrs_byte_mem #(.AW(8)) u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .we      (accept),
    .waddr   (rx_len[7:0]),
    .wdata   (rx_sh),
    .raddr   (mem_raddr[7:0]),
    .rdata   (mem_rdata)
  );

  // frame bookkeeping: arming, frame open and close, length count and fault flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed     <= 1'b0;
      in_frame  <= 1'b0;
      frame_bad <= 1'b0;
      rx_len    <= 9'h000;
    end else begin
      if (line_quiet) begin
        armed <= 1'b1;
      end
      if (frame_end) begin
        in_frame <= 1'b0;
      end
      if (accept) begin
        armed    <= 1'b0;
        in_frame <= 1'b1;
        rx_len   <= first_b ? 9'h001 : rx_len + 9'h001;
        if (first_b) begin
          frame_bad <= rx_ferr || !addr_hit;
        end else if (rx_ferr || rx_len[8]) begin
          frame_bad <= 1'b1;
        end
      end
    end
  end

  // header fields and the check code held two bytes back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc     <= 8'h00;
      start  <= 16'h0000;
      count  <= 16'h0000;
      bcount <= 8'h00;
      last_b <= 8'h00;
      prev_b <= 8'h00;
      crc_d1 <= CRC_PRESET;
      crc_d2 <= CRC_PRESET;
    end else if (accept) begin
      last_b <= rx_sh;
      prev_b <= last_b;
      crc_d1 <= first_b ? CRC_PRESET : rx_crc;
      crc_d2 <= crc_d1;
      if (!first_b) begin
        unique case (rx_len)
          IDX_FC:       fc          <= rx_sh;
          IDX_START_HI: start[15:8] <= rx_sh;
          IDX_START_LO: start[7:0]  <= rx_sh;
          IDX_COUNT_HI: count[15:8] <= rx_sh;
          IDX_COUNT_LO: count[7:0]  <= rx_sh;
          IDX_BCOUNT:   bcount      <= rx_sh;
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // request evaluation
  // ****************************************************************
  wire [16:0] end_addr = {1'b0, start} + {1'b0, count} - 17'h00001;
  wire        crc_ok   = (crc_d2 == {last_b, prev_b});
  wire        good     = !frame_bad && (rx_len >= MIN_LEN) && crc_ok;
  wire        is_rd    = (fc == FC_READ);
  wire        is_wr    = (fc == FC_WRITE);
  wire        addr_ok  = (count != 16'h0000) && (start >= 16'(REG_FIRST))
                         && (end_addr <= 17'(REG_LAST));
  wire        rd_ok    = (rx_len == READ_LEN) && (count <= READ_MAX_REGS);
  wire        wr_ok    = (count <= WRITE_MAX_REGS) && (bcount == {count[6:0], 1'b0})
                         && (rx_len == WRITE_OVERHEAD + {1'b0, bcount});
  // first fault wins: function, then address, then data
  wire [7:0]  eval_err = !(is_rd || is_wr) ? ERR_FUNC :
                         !addr_ok          ? ERR_ADDR :
                         !(is_rd ? rd_ok : wr_ok) ? ERR_DATA : ERR_NONE;

  // ****************************************************************
  // control sequence
  // ****************************************************************
  logic [7:0]    err_code;
  logic [6:0]    wi;
  logic [2:0]    ph;
  logic          pass;
  logic [15:0]   word;
  logic          fetched;
  logic [8:0]    tx_idx;
  logic [8:0]    tx_body;
  logic          tx_clr;
  logic [9:0]    tx_sh;
  logic [3:0]    tx_left;
  logic [DW-1:0] tx_div;
  logic [15:0]   tx_crc;

  wire [8:0]  word_base = IDX_WR_DATA + {1'b0, wi, 1'b0};
  assign mem_raddr      = word_base + {8'h00, (ph != 3'h0)};
  wire        last_word = ({9'h000, wi} == count - 16'h0001);
  wire [8:0]  tx_woff   = tx_idx - RSP_READ_HDR;
  wire        in_body   = tx_idx < tx_body;
  wire        need_word = (kind == KIND_READ) && (tx_idx >= RSP_READ_HDR) && in_body
                          && tx_idx[0] && !fetched;
  wire        tx_fin    = (tx_idx == tx_body + 9'h002);
  wire        tx_load   = (state == ST_TX_NEXT) && !tx_fin && !need_word;
  wire [7:0]  echo_b    = (tx_idx == IDX_START_HI) ? start[15:8] :
                          (tx_idx == IDX_START_LO) ? start[7:0]  :
                          (tx_idx == IDX_COUNT_HI) ? count[15:8] : count[7:0];
  // reply byte selection; check code low byte first
  wire [7:0]  tx_byte   = (tx_idx == tx_body)          ? tx_crc[7:0]  :
                          (tx_idx == tx_body + 9'h001) ? tx_crc[15:8] :
                          (tx_idx == IDX_ADDR)         ? dev_addr     :
                          (tx_idx == IDX_FC)           ?
                            ((kind == KIND_EXC) ? (fc | EXC_FLAG) : fc) :
                          (kind == KIND_EXC)           ? err_code     :
                          (kind == KIND_WRITE)         ? echo_b       :
                          (tx_idx == IDX_START_HI)     ? {count[6:0], 1'b0} :
                          tx_idx[0] ? word[15:8] : word[7:0];

  // reply check code is built from the bytes as they leave
  mbrs_crc16 u_tx_crc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clear   (tx_clr),
    .en      (tx_load && in_body),
    .data    (tx_byte),
    .crc     (tx_crc)
  );

  // main sequencer: evaluate, check and write words, then send the reply
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_RX;
      kind       <= KIND_EXC;
      err_code   <= ERR_NONE;
      wi         <= 7'h00;
      ph         <= 3'h0;
      pass       <= 1'b0;
      word       <= 16'h0000;
      fetched    <= 1'b0;
      tx_idx     <= 9'h000;
      tx_body    <= 9'h000;
      tx_clr     <= 1'b0;
      reg_req    <= '0;
      frame_drop <= 1'b0;
      reply_done <= 1'b0;
    end else begin
      tx_clr      <= 1'b0;
      reg_req.rd  <= 1'b0;
      reg_req.wr  <= 1'b0;
      reg_req.chk <= 1'b0;
      frame_drop  <= 1'b0;
      reply_done  <= 1'b0;
      tx_idx      <= 9'h000;
      unique case (state)
        ST_RX: begin
          if (frame_end) begin
            state      <= good ? ST_EVAL : ST_RX;
            frame_drop <= !good;
          end
        end
        ST_EVAL: begin
          err_code <= eval_err;
          wi       <= 7'h00;
          ph       <= 3'h0;
          pass     <= 1'b0;
          fetched  <= 1'b0;
          tx_clr   <= 1'b1;
          if (eval_err != ERR_NONE) begin
            kind    <= KIND_EXC;
            tx_body <= RSP_EXC_BODY;
            state   <= ST_TX_NEXT;
          end else if (is_rd) begin
            kind    <= KIND_READ;
            tx_body <= RSP_READ_HDR + {count[7:0], 1'b0};
            state   <= ST_TX_NEXT;
          end else begin
            state   <= ST_WORDS;
          end
        end
        ST_WORDS: begin
          // two passes: every value is checked before any is written
          ph <= ph + 3'h1;
          if (ph == 3'h1) begin
            word[15:8] <= mem_rdata;
          end
          if (ph == 3'h2) begin
            reg_req.chk   <= !pass;
            reg_req.wr    <= pass;
            reg_req.addr  <= start + {9'h000, wi};
            reg_req.wdata <= {word[15:8], mem_rdata};
          end
          if (ph == 3'h4) begin
            ph <= 3'h0;
            if (!pass && !reg_rsp.ok) begin
              kind     <= KIND_EXC;
              err_code <= ERR_DATA;
              tx_body  <= RSP_EXC_BODY;
              tx_clr   <= 1'b1;
              state    <= ST_TX_NEXT;
            end else if (!last_word) begin
              wi <= wi + 7'h01;
            end else if (!pass) begin
              pass <= 1'b1;
              wi   <= 7'h00;
            end else begin
              kind    <= KIND_WRITE;
              tx_body <= RSP_WRITE_BODY;
              tx_clr  <= 1'b1;
              state   <= ST_TX_NEXT;
            end
          end
        end
        ST_TX_NEXT: begin
          tx_idx <= tx_idx;
          if (tx_fin) begin
            state      <= ST_RX;
            reply_done <= 1'b1;
          end else if (need_word) begin
            reg_req.rd   <= 1'b1;
            reg_req.addr <= start + {8'h00, tx_woff[8:1]};
            ph           <= 3'h0;
            state        <= ST_TX_FETCH;
          end else begin
            state <= ST_TX_BIT;
          end
        end
        ST_TX_FETCH: begin
          // register data arrive the cycle after the strobe is seen
          tx_idx <= tx_idx;
          ph     <= 3'h1;
          if (ph == 3'h1) begin
            word    <= reg_rsp.rdata;
            fetched <= 1'b1;
            state   <= ST_TX_NEXT;
          end
        end
        ST_TX_BIT: begin
          tx_idx <= tx_idx;
          if (tx_div == '0 && tx_left == 4'h0) begin
            tx_idx  <= tx_idx + 9'h001;
            fetched <= 1'b0;
            state   <= ST_TX_NEXT;
          end
        end
        default: state <= ST_RX;
      endcase
    end
  end

  // ****************************************************************
  // transmit character: start, eight data lsb first, two stops
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin   <= 1'b1;
      tx_drive <= 1'b0;
      tx_sh    <= 10'h3FF;
      tx_left  <= 4'h0;
      tx_div   <= '0;
    end else begin
      tx_drive <= (state != ST_RX) && (state != ST_EVAL) && (state != ST_WORDS);
      if (tx_load) begin
        tx_pin  <= 1'b0;
        tx_sh   <= {2'b11, tx_byte};
        tx_left <= TX_TAIL_BITS;
        tx_div  <= DW'(BIT_CYC - 1);
      end else if (state == ST_TX_BIT && tx_div == '0 && tx_left != 4'h0) begin
        tx_pin  <= tx_sh[0];
        tx_sh   <= {1'b1, tx_sh[9:1]};
        tx_left <= tx_left - 4'h1;
        tx_div  <= DW'(BIT_CYC - 1);
      end else if (tx_div != '0) begin
        tx_div <= tx_div - DW'(1);
      end
    end
  end

endmodule : mbrs_frame_engine
`default_nettype wire

// ===== hw/mbrs_pkg.sv
// shared constants and types for the serial register-access frame engine
package mbrs_pkg;

  // ****************************************************************
  // function, exception and error codes, device address range
  // ****************************************************************
  localparam logic [7:0]  FC_READ        = 8'h03;
  localparam logic [7:0]  FC_WRITE       = 8'h10;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  ERR_NONE       = 8'h00;
  localparam logic [7:0]  ERR_FUNC       = 8'h01;
  localparam logic [7:0]  ERR_ADDR       = 8'h02;
  localparam logic [7:0]  ERR_DATA       = 8'h03;
  localparam logic [7:0]  ADDR_MIN       = 8'h01;
  localparam logic [7:0]  ADDR_MAX       = 8'hF7;

  // ****************************************************************
  // check code and character timing
  // ****************************************************************
  localparam logic [15:0] CRC_PRESET     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam int          CHAR_BITS      = 11;
  localparam int          GAP_HALF_CHARS = 7;
  localparam logic [3:0]  RX_STOP_POS    = 4'h9;
  localparam logic [3:0]  TX_TAIL_BITS   = 4'hA;

  // ****************************************************************
  // byte positions and lengths inside frames, register count limits
  // ****************************************************************
  localparam logic [8:0]  IDX_ADDR       = 9'h000;
  localparam logic [8:0]  IDX_FC         = 9'h001;
  localparam logic [8:0]  IDX_START_HI   = 9'h002;
  localparam logic [8:0]  IDX_START_LO   = 9'h003;
  localparam logic [8:0]  IDX_COUNT_HI   = 9'h004;
  localparam logic [8:0]  IDX_COUNT_LO   = 9'h005;
  localparam logic [8:0]  IDX_BCOUNT     = 9'h006;
  localparam logic [8:0]  IDX_WR_DATA    = 9'h007;
  localparam logic [8:0]  MIN_LEN        = 9'h004;
  localparam logic [8:0]  READ_LEN       = 9'h008;
  localparam logic [8:0]  WRITE_OVERHEAD = 9'h009;
  localparam logic [8:0]  RSP_READ_HDR   = 9'h003;
  localparam logic [8:0]  RSP_WRITE_BODY = 9'h006;
  localparam logic [8:0]  RSP_EXC_BODY   = 9'h003;
  localparam logic [15:0] READ_MAX_REGS  = 16'h007D;
  localparam logic [15:0] WRITE_MAX_REGS = 16'h007B;

  // ****************************************************************
  // carriers and state codes
  // ****************************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        chk;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbrs_reg_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        ok;
  } mbrs_reg_rsp_t;

  typedef enum logic [5:0] {
    ST_RX       = 6'b000001,
    ST_EVAL     = 6'b000010,
    ST_WORDS    = 6'b000100,
    ST_TX_NEXT  = 6'b001000,
    ST_TX_FETCH = 6'b010000,
    ST_TX_BIT   = 6'b100000
  } mbrs_state_t;

  typedef enum logic [2:0] {
    KIND_READ  = 3'b001,
    KIND_WRITE = 3'b010,
    KIND_EXC   = 3'b100
  } mbrs_kind_t;

endpackage : mbrs_pkg

// ===== hw/mbrs_crc16.sv
// byte-wide 16-bit check code register, eight shift steps per byte
`timescale 1ns/1ps
`default_nettype none
module mbrs_crc16 (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // control and data
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // result
  output logic      [15:0] crc
);
  import mbrs_pkg::*;

  logic [15:0] seed;
  logic [15:0] step [0:8];

  // a clear together with a byte folds the byte into a fresh preset
  assign seed    = clear ? CRC_PRESET : crc;
  assign step[0] = seed ^ {8'h00, data};

  // each step: shift right, zero fill, xor the polynomial on a one out
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_shift
      assign step[i+1] = step[i][0] ? ((step[i] >> 1) ^ CRC_POLY) : (step[i] >> 1);
    end
  endgenerate

  // register update
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_PRESET;
    end else if (en) begin
      crc <= step[8];
    end else if (clear) begin
      crc <= CRC_PRESET;
    end
  end

endmodule : mbrs_crc16
`default_nettype wire

// ===== hw/mbrs_byte_mem.sv
// frame byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module mbrs_byte_mem #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port, data one cycle after the address
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [0:(1<<AW)-1];

  // storage has no reset; only bytes of the current frame are ever read
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : mbrs_byte_mem
`default_nettype wire

// ===== dv/mbrs_frame_engine_properties.sv
// concurrent checks on the frame engine's serial, status and register request ports
`timescale 1ns/1ps
`default_nettype none
module mbrs_frame_engine_properties #(
  parameter int unsigned SILENCE_CYCLES = 40
) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // serial line
  input wire logic                    rx_pin,
  input wire logic                    tx_pin,
  input wire logic                    tx_drive,
  // configuration and register map
  input wire logic [7:0]              dev_addr,
  input wire mbrs_pkg::mbrs_reg_req_t reg_req,
  input wire mbrs_pkg::mbrs_reg_rsp_t reg_rsp,
  // status
  input wire logic                    frame_drop,
  input wire logic                    reply_done
);
  import mbrs_pkg::*;
  // ****************************************
  // receive silence counter
  // ****************************************
  logic [15:0] quiet; // saturates so a long idle never wraps to a false short gap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) quiet <= 16'h0000;
    else if (!rx_pin) quiet <= 16'h0000;
    else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  idle_high_a: assert property (!tx_drive |-> tx_pin)
    else $error("tx line low while not driving");
  start_len_a: assert property ($fell(tx_pin) |-> (!tx_pin) [*8])
    else $error("tx low level shorter than a bit");
  reply_gap_a: assert property ($fell(tx_pin) |-> {16'h0000, quiet} >= SILENCE_CYCLES)
    else $error("reply started without request silence");
  drive_tx_a: assert property ($fell(tx_pin) |-> tx_drive)
    else $error("tx bit sent with driver off");
  drop_silent_a: assert property (frame_drop |-> (!tx_drive) [*8])
    else $error("reply begun for dropped frame");
  drop_pulse_a: assert property (frame_drop |=> !frame_drop)
    else $error("drop flag longer than one cycle");
  done_pulse_a: assert property (reply_done |=> !reply_done)
    else $error("done flag longer than one cycle");
  stop_high_a: assert property (reply_done |-> tx_pin && $past(tx_pin))
    else $error("reply ended without high stop");
  req_excl_a: assert property (reg_req.wr |-> !reg_req.rd && !reg_req.chk)
    else $error("write overlaps read or check");
endmodule : mbrs_frame_engine_properties
bind mbrs_frame_engine mbrs_frame_engine_properties #(.SILENCE_CYCLES(SILENCE_CYCLES))
  mbrs_frame_engine_properties_i (.ref_clk(ref_clk), .rst_n(rst_n), .rx_pin(rx_pin),
  .tx_pin(tx_pin), .tx_drive(tx_drive), .dev_addr(dev_addr), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .frame_drop(frame_drop), .reply_done(reply_done));
`default_nettype wire

// ===== dv/mbrs_host_model.sv
// host computer model: sends request characters, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module mbrs_host_model #(
  parameter int BIT_CYC = 10
) (
  // clock
  input  wire logic ref_clk,
  // serial line
  output var logic  rx_pin,
  input  wire logic tx_pin
);
  // ****************************************
  // transmit and receive
  // ****************************************
  logic [7:0] got[$], sh; // reply bytes in arrival order
  initial rx_pin = 1'b1;
  // leading silence, then start low, eight data lsb first, two high stops
  task automatic send(input logic [7:0] b[$]);
    logic [10:0] ch;
    repeat (6 * BIT_CYC) @(posedge ref_clk);
    foreach (b[i]) begin
      ch = {2'b11, b[i], 1'b0};
      for (int k = 0; k < 11; k++) begin
        #1 rx_pin = ch[k];
        repeat (BIT_CYC) @(posedge ref_clk);
      end
    end
  endtask : send
  // sample at mid-bit; a glitch under half a bit reads as a start
  initial begin
    forever begin
      @(posedge ref_clk);
      if (tx_pin === 1'b0) begin
        repeat (BIT_CYC / 2 + BIT_CYC) @(posedge ref_clk);
        for (int k = 0; k < 8; k++) begin
          sh[k] = tx_pin;
          repeat (BIT_CYC) @(posedge ref_clk);
        end
        got.push_back(sh);
      end
    end
  end
endmodule : mbrs_host_model
`default_nettype wire

// ===== dv/mbrs_frame_engine_tb_top.sv
// self-checking bench for the frame engine
`timescale 1ns/1ps
`default_nettype none
module mbrs_frame_engine_tb_top;
  import mbrs_pkg::*;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
  // ****************************************
  // signals, design and partners
  // ****************************************
  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] start;
    logic [15:0] cnt;
    logic [15:0] val;
    logic [7:0]  err;
  } mbrs_row_t;
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b1;
  logic          rx_pin, tx_pin, tx_drive, frame_drop, reply_done;
  logic [7:0]    dev_addr = 8'h01;
  mbrs_reg_req_t req;
  mbrs_reg_rsp_t rsp = '0;
  logic [15:0]   mem[256], shadow[256];
  int            error_cnt = 0, checks = 0;
  always #50 ref_clk = ~ref_clk;
  mbrs_frame_engine #(.BAUD(1_000_000), .SILENCE_CYCLES(40)) mbrs_frame_engine_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_drive(tx_drive),
    .dev_addr(dev_addr), .reg_req(req), .reg_rsp(rsp), .frame_drop(frame_drop),
    .reply_done(reply_done));
  mbrs_host_model mbrs_host_model_i (.ref_clk(ref_clk), .rx_pin(rx_pin), .tx_pin(tx_pin));
  // register map: answers a cycle after rd or chk, refuses FFFF
  always @(posedge ref_clk) begin
    #1 rsp = '{rdata: mem[req.addr[7:0]], ok: req.wdata !== 16'hFFFF};
    if (req.wr === 1'b1) mem[req.addr[7:0]] = req.wdata;
  end
  mbrs_row_t rows[] = '{
    '{FC_READ, 16'h000C, 16'h0002, 16'h0000, ERR_NONE}, '{FC_WRITE, 16'h0000, 16'h0003,
    16'h1388, ERR_NONE}, '{FC_READ, 16'h0000, 16'h0003, 16'h0000, ERR_NONE},
    '{8'h06, 16'h0100, 16'h0000, 16'h0000, ERR_FUNC}, '{FC_READ, 16'h0100, 16'h0001,
    16'h0000, ERR_ADDR}, '{FC_READ, 16'h0000, 16'h0000, 16'h0000, ERR_ADDR},
    '{FC_READ, 16'h00FF, 16'h0002, 16'h0000, ERR_ADDR}, '{FC_READ, 16'h00FF, 16'h0001,
    16'h0000, ERR_NONE}, '{FC_READ, 16'h0000, 16'h007E, 16'h0000, ERR_DATA},
    '{FC_WRITE, 16'h0005, 16'h0002, 16'hFFFF, ERR_DATA}, '{FC_READ, 16'h0005, 16'h0002,
    16'h0000, ERR_NONE}};
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // bounded wait on the drop flag or the done flag
  task automatic wait_hi(input bit drop, input int lim);
    int k;
    k = 0;
    while ((drop ? frame_drop : reply_done) !== 1'b1 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == lim) begin
      error_cnt++;
      $display("ERROR wait expected flag seen timeout");
      wrap_up();
    end
  endtask : wait_hi
  // one request; expected reply from the row and the shadow map
  task automatic run(input mbrs_row_t r, input logic [7:0] a, input logic bad);
    logic [7:0]  q[$], e[$];
    logic [15:0] c;
    q = '{a, r.fc, r.start[15:8], r.start[7:0], r.cnt[15:8], r.cnt[7:0]};
    if (r.fc == FC_WRITE) q.push_back(8'(r.cnt * 2));
    for (int i = 0; i < int'(r.cnt) && r.fc == FC_WRITE; i++) begin
      c = r.val + 16'(i);
      q.push_back(c[15:8]);
      q.push_back(c[7:0]);
    end
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8] ^ {7'h00, bad});
    if (r.err != ERR_NONE) e = '{a, r.fc | EXC_FLAG, r.err};
    else if (r.fc == FC_READ) e = '{a, r.fc, 8'(r.cnt * 2)};
    else e = q[0:5];
    for (int i = 0; i < int'(r.cnt) && r.err == ERR_NONE; i++) begin
      c = shadow[8'(r.start + 16'(i))];
      if (r.fc == FC_READ) e.push_back(c[15:8]);
      if (r.fc == FC_READ) e.push_back(c[7:0]);
      if (r.fc == FC_WRITE && !bad && a == dev_addr) shadow[8'(r.start + 16'(i))] = r.val + 16'(i);
    end
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    mbrs_host_model_i.got.delete();
    mbrs_host_model_i.send(q);
    wait_hi(bad || a != dev_addr, 30000);
    repeat (300) @(posedge ref_clk);
    if (bad || a != dev_addr) e.delete();
    `CHK("reply length", e.size(), mbrs_host_model_i.got.size())
    foreach (e[i]) `CHK("reply byte", e[i], mbrs_host_model_i.got[i])
    $display("test done fc %h addr %h", r.fc, a);
  endtask : run
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[8'h0D] = 16'h1388;
    shadow = mem;
    `CHK("check code", 16'h0804, crc16('{8'h01, 8'h03, 8'h00, 8'h0C, 8'h00, 8'h02}))
    #1 rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("reset outputs", 4'b1000, {tx_pin, tx_drive, frame_drop, reply_done})
    `CHK("reset request", '0, req)
    #1 rst_n = 1'b1;
    foreach (rows[i]) run(rows[i], dev_addr, 1'b0);
    run(rows[0], dev_addr, 1'b1);
    run(rows[0], 8'h02, 1'b0);
    #1 dev_addr = 8'hF7;
    run(rows[0], 8'hF7, 1'b0);
    wrap_up();
  end
endmodule : mbrs_frame_engine_tb_top
`default_nettype wire
